//--- src/kbdss_pkg.sv
// Package of register indices, field positions and reset values.
package kbdss_pkg;

    // -------------------------------------------------------------------
    // Configuration indices (byte address is four times the index)
    // -------------------------------------------------------------------
    localparam logic [7:0] IDX_LDN        = 8'h07;
    localparam logic [7:0] IDX_SELECT     = 8'hF0;
    localparam logic [7:0] IDX_RSVD_LO    = 8'hF1;
    localparam logic [7:0] IDX_RSVD_HI    = 8'hFF;
    localparam logic [7:0] IDX_IRQ_STATUS = 8'hE0;
    localparam logic [7:0] IDX_IRQ_MASK   = 8'hE1;
    localparam logic [7:0] LDN_KBD        = 8'h07;
    localparam int         IDX_LSB        = 2;
    localparam int         ADDR_W         = 10;

    // -------------------------------------------------------------------
    // Select register layout
    // -------------------------------------------------------------------
    localparam int         SEL_P12_POL     = 7;
    localparam int         SEL_MOUSE_ISO   = 6;
    localparam int         SEL_KBD_ISO     = 5;
    localparam int         SEL_MOUSE_LATCH = 4;
    localparam int         SEL_KBD_LATCH   = 3;
    localparam int         SEL_SYS_PORT    = 2;
    localparam logic [7:0] SELECT_RESET    = 8'h00;
    localparam logic [7:0] SELECT_WMASK    = 8'hFC;
    localparam logic [7:0] SELECT_ISO_MASK = 8'h60;
    localparam logic [7:0] LDN_RESET       = 8'h00;

    // -------------------------------------------------------------------
    // Interrupt status and mask layout
    // -------------------------------------------------------------------
    localparam int         IRQ_KBD_BIT   = 0;
    localparam int         IRQ_MOUSE_BIT = 1;
    localparam int         IRQ_W         = 2;
    localparam logic [1:0] IRQ_RESET     = 2'h0;

    typedef enum logic {
        BUS_IDLE,
        BUS_ANSWER
    } kbdss_bus_state_t;

endpackage : kbdss_pkg

//--- src/kbdss_irq_if.sv
// Interface carrying one interrupt path between the top and its shaper.
`timescale 1ns/1ps
interface kbdss_irq_if;
    logic raw;
    logic ack;
    logic latch_sel;
    logic irq;
    logic latched;
    logic rise;

    modport shaper (
        input  raw,
        input  ack,
        input  latch_sel,
        output irq,
        output latched,
        output rise
    );
    modport ctrl (
        output raw,
        output ack,
        output latch_sel,
        input  irq,
        input  latched,
        input  rise
    );
endinterface : kbdss_irq_if

//--- src/kbdss_irq_shaper.sv
// Latches one microcontroller interrupt and shapes the output form.
`timescale 1ns/1ps
module kbdss_irq_shaper
    import kbdss_pkg::*;
(
    input  wire logic   i_clk,
    input  wire logic   i_reset_n,
    kbdss_irq_if.shaper irq_bus
);

    logic raw_q;
    logic next_latched;

    // -------------------------------------------------------------------
    // Latch: a new rising edge wins over an acknowledge in the same cycle
    // -------------------------------------------------------------------
    always_comb begin
        next_latched = irq_bus.latched;
        if (irq_bus.ack) begin
            next_latched = 1'b0;
        end
        if (irq_bus.raw && !raw_q) begin
            next_latched = 1'b1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            raw_q           <= 1'b0;
            irq_bus.latched <= 1'b0;
            irq_bus.rise    <= 1'b0;
        end else begin
            raw_q           <= irq_bus.raw;
            irq_bus.latched <= next_latched;
            irq_bus.rise    <= irq_bus.raw && !raw_q;
        end
    end

    // -------------------------------------------------------------------
    // Output form
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (!i_reset_n) begin
            irq_bus.irq <= 1'b0;
        end else if (irq_bus.latch_sel) begin
            irq_bus.irq <= next_latched;
        end else begin
            irq_bus.irq <= next_latched && irq_bus.raw;
        end
    end

    a_irq_latched_form: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        $past(irq_bus.latch_sel) |-> irq_bus.irq == irq_bus.latched)
        else $error("latched form differs from latch");
    a_irq_anded_form: assert property (@(posedge i_clk)
        disable iff (!i_reset_n)
        !$past(irq_bus.latch_sel) |->
            irq_bus.irq == (irq_bus.latched && $past(irq_bus.raw)))
        else $error("anded form differs from raw and latch");

endmodule : kbdss_irq_shaper

//--- src/kbdss_signal_select.sv
// Keyboard controller signal select register with its line gating.
// Function
// - Bit 7 picks controller port bit twelve polarity, low by default.
// - Mouse isolation bit 6 blocks mouse clock and data to microcontroller.
// - Mouse wakeup data line is never gated by mouse isolation.
// - Keyboard isolation bit 5 blocks keyboard lines to microcontroller.
// - Keyboard wakeup data line is never gated by keyboard isolation.
// - Bit 4 low: mouse interrupt is raw AND latched; high: latched only.
// - Bit 3 low: keyboard interrupt is raw AND latched; high: latched only.
// - Bits 1:0 reserved; indices F1 to FF read as zero.
// - Resets clear to zero; isolation bits clear on standby power-on only.
// - Select register lives in logical device seven of the index space.
`timescale 1ns/1ps
module kbdss_signal_select
    import kbdss_pkg::*;
(
    input  wire logic              i_clk,
    input  wire logic              i_reset_n,
    input  wire logic              i_main_por_n,
    input  wire logic              i_standby_por_n,
    input  wire logic [ADDR_W-1:0] i_avs_address,
    input  wire logic              i_avs_read,
    input  wire logic              i_avs_write,
    input  wire logic [31:0]       i_avs_writedata,
    input  wire logic [3:0]        i_avs_byteenable,
    output logic      [31:0]       o_avs_readdata,
    output logic                   o_avs_waitrequest,
    input  wire logic              i_kbd_clk_line,
    input  wire logic              i_kbd_data_line,
    input  wire logic              i_mouse_clk_line,
    input  wire logic              i_mouse_data_line,
    output logic                   o_kbd_clk_to_mcu,
    output logic                   o_kbd_data_to_mcu,
    output logic                   o_mouse_clk_to_mcu,
    output logic                   o_mouse_data_to_mcu,
    output logic                   o_kbd_wake_data,
    output logic                   o_mouse_wake_data,
    input  wire logic              i_ctrl_port_bit_twelve,
    output logic                   o_kbd_driven_cpu_reset,
    input  wire logic              i_mcu_kbd_irq,
    input  wire logic              i_mcu_mouse_irq,
    input  wire logic              i_kbd_irq_ack,
    input  wire logic              i_mouse_irq_ack,
    output logic                   o_kbd_irq,
    output logic                   o_mouse_irq,
    output logic                   o_sys_ctrl_port_en,
    output logic                   o_irq
);

    kbdss_bus_state_t   bus_state;
    logic [7:0]         select_main;
    logic [7:0]         select_iso;
    logic [7:0]         kbd_signal_select;
    logic [7:0]         ldn;
    logic [IRQ_W-1:0]   irq_status;
    logic [IRQ_W-1:0]   irq_mask;
    logic [IRQ_W-1:0]   next_irq_status;
    logic [IRQ_W-1:0]   irq_events;
    logic [7:0]         req_idx;
    logic [31:0]        next_readdata;
    logic               any_rst;
    logic               settled;
    logic               wr_done;
    logic               rd_done;
    logic               wr_lane0;

    kbdss_irq_if kbd_if ();
    kbdss_irq_if mouse_if ();

    // -------------------------------------------------------------------
    // Decoding
    // -------------------------------------------------------------------
    function automatic logic is_select(input logic [7:0] idx,
                                       input logic [7:0] dev);
        return (idx == IDX_SELECT) && (dev == LDN_KBD);
    endfunction : is_select

    function automatic logic is_reserved(input logic [7:0] idx);
        return (idx >= IDX_RSVD_LO) && (idx <= IDX_RSVD_HI);
    endfunction : is_reserved

    assign any_rst  = !i_reset_n || !i_main_por_n || !i_standby_por_n;
    assign req_idx  = i_avs_address[IDX_LSB +: 8];
    assign wr_done  = (bus_state == BUS_ANSWER) && i_avs_write;
    assign rd_done  = (bus_state == BUS_ANSWER) && i_avs_read;
    assign wr_lane0 = wr_done && i_avs_byteenable[0];
    assign kbd_signal_select = (select_main & ~SELECT_ISO_MASK)
                             | (select_iso & SELECT_ISO_MASK);

    // -------------------------------------------------------------------
    // Bus handshake
    // -------------------------------------------------------------------
    // Every access is answered one cycle after it is seen, so waitrequest
    // drops for exactly the completing edge and never stalls longer.
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            bus_state         <= BUS_IDLE;
            o_avs_waitrequest <= 1'b1;
        end else begin
            case (bus_state)
                BUS_IDLE: begin
                    if (i_avs_read || i_avs_write) begin
                        bus_state         <= BUS_ANSWER;
                        o_avs_waitrequest <= 1'b0;
                    end
                end
                BUS_ANSWER: begin
                    bus_state         <= BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
                default: begin
                    bus_state         <= BUS_IDLE;
                    o_avs_waitrequest <= 1'b1;
                end
            endcase
        end
    end

    // -------------------------------------------------------------------
    // Read data
    // -------------------------------------------------------------------
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (req_idx == IDX_LDN) begin
            next_readdata[7:0] = ldn;
        end else if (is_select(req_idx, ldn)) begin
            next_readdata[7:0] = kbd_signal_select & SELECT_WMASK;
        end else if (req_idx == IDX_IRQ_STATUS) begin
            next_readdata[IRQ_W-1:0] = irq_status;
        end else if (req_idx == IDX_IRQ_MASK) begin
            next_readdata[IRQ_W-1:0] = irq_mask;
        end else if (is_reserved(req_idx)) begin
            next_readdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            o_avs_readdata <= 32'h0000_0000;
        end else if ((bus_state == BUS_IDLE) && i_avs_read) begin
            o_avs_readdata <= next_readdata;
        end
    end

    // -------------------------------------------------------------------
    // Configuration registers
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            ldn <= LDN_RESET;
        end else if (wr_lane0 && (req_idx == IDX_LDN)) begin
            ldn <= i_avs_writedata[7:0];
        end
    end

    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            select_main <= SELECT_RESET;
        end else if (wr_lane0 && is_select(req_idx, ldn)) begin
            select_main <= i_avs_writedata[7:0] & SELECT_WMASK;
        end
    end

    // The isolation bits survive bus and main-supply resets so that a
    // keyboard kept quiet for wakeup stays isolated across a host reboot.
    always_ff @(posedge i_clk) begin
        if (!i_standby_por_n) begin
            select_iso <= SELECT_RESET;
        end else if (wr_lane0 && is_select(req_idx, ldn)) begin
            select_iso <= i_avs_writedata[7:0] & SELECT_ISO_MASK;
        end
    end

    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            irq_mask <= IRQ_RESET;
        end else if (wr_lane0 && (req_idx == IDX_IRQ_MASK)) begin
            irq_mask <= i_avs_writedata[IRQ_W-1:0];
        end
    end

    // -------------------------------------------------------------------
    // Interrupt status
    // -------------------------------------------------------------------
    assign irq_events[IRQ_KBD_BIT]   = kbd_if.rise;
    assign irq_events[IRQ_MOUSE_BIT] = mouse_if.rise;

    always_comb begin
        next_irq_status = irq_status;
        if (rd_done && (req_idx == IDX_IRQ_STATUS)) begin
            next_irq_status = IRQ_RESET;
        end
        next_irq_status = next_irq_status | irq_events;
    end

    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            irq_status <= IRQ_RESET;
            o_irq      <= 1'b0;
        end else begin
            irq_status <= next_irq_status;
            o_irq      <= |(next_irq_status & irq_mask);
        end
    end

    // -------------------------------------------------------------------
    // Line gating toward the microcontroller
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            o_mouse_clk_to_mcu  <= 1'b1;
            o_mouse_data_to_mcu <= 1'b1;
        end else if (kbd_signal_select[SEL_MOUSE_ISO]) begin
            o_mouse_clk_to_mcu  <= 1'b1;
            o_mouse_data_to_mcu <= 1'b1;
        end else begin
            o_mouse_clk_to_mcu  <= i_mouse_clk_line;
            o_mouse_data_to_mcu <= i_mouse_data_line;
        end
    end

    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            o_kbd_clk_to_mcu  <= 1'b1;
            o_kbd_data_to_mcu <= 1'b1;
        end else if (kbd_signal_select[SEL_KBD_ISO]) begin
            o_kbd_clk_to_mcu  <= 1'b1;
            o_kbd_data_to_mcu <= 1'b1;
        end else begin
            o_kbd_clk_to_mcu  <= i_kbd_clk_line;
            o_kbd_data_to_mcu <= i_kbd_data_line;
        end
    end

    // Wakeup paths see the pins unconditionally.
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            o_kbd_wake_data   <= 1'b1;
            o_mouse_wake_data <= 1'b1;
        end else begin
            o_kbd_wake_data   <= i_kbd_data_line;
            o_mouse_wake_data <= i_mouse_data_line;
        end
    end

    // -------------------------------------------------------------------
    // Port bit polarity and system-control port
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (any_rst) begin
            o_kbd_driven_cpu_reset <= 1'b0;
            o_sys_ctrl_port_en     <= 1'b0;
        end else begin
            o_kbd_driven_cpu_reset <= kbd_signal_select[SEL_P12_POL]
                                    ? i_ctrl_port_bit_twelve
                                    : !i_ctrl_port_bit_twelve;
            o_sys_ctrl_port_en <= kbd_signal_select[SEL_SYS_PORT];
        end
    end

    // -------------------------------------------------------------------
    // Interrupt shapers
    // -------------------------------------------------------------------
    assign kbd_if.raw         = i_mcu_kbd_irq;
    assign kbd_if.ack         = i_kbd_irq_ack;
    assign kbd_if.latch_sel   = kbd_signal_select[SEL_KBD_LATCH];
    assign mouse_if.raw       = i_mcu_mouse_irq;
    assign mouse_if.ack       = i_mouse_irq_ack;
    assign mouse_if.latch_sel = kbd_signal_select[SEL_MOUSE_LATCH];
    assign o_kbd_irq          = kbd_if.irq;
    assign o_mouse_irq        = mouse_if.irq;

    kbdss_irq_shaper u_kbd_shaper (
        .i_clk     (i_clk),
        .i_reset_n (!any_rst),
        .irq_bus   (kbd_if.shaper)
    );

    kbdss_irq_shaper u_mouse_shaper (
        .i_clk     (i_clk),
        .i_reset_n (!any_rst),
        .irq_bus   (mouse_if.shaper)
    );

    // -------------------------------------------------------------------
    // Checks
    // -------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        settled <= !any_rst;
    end

    a_p12_polarity: assert property (@(posedge i_clk)
        disable iff (any_rst || !settled)
        o_kbd_driven_cpu_reset == ($past(kbd_signal_select[SEL_P12_POL])
            ? $past(i_ctrl_port_bit_twelve)
            : !$past(i_ctrl_port_bit_twelve)))
        else $error("port bit twelve polarity wrong");

    a_mouse_iso_block: assert property (@(posedge i_clk)
        disable iff (any_rst || !settled)
        $past(kbd_signal_select[SEL_MOUSE_ISO]) |->
            (o_mouse_clk_to_mcu && o_mouse_data_to_mcu))
        else $error("mouse lines not held idle while isolated");

    a_mouse_pass: assert property (@(posedge i_clk)
        disable iff (any_rst || !settled)
        !$past(kbd_signal_select[SEL_MOUSE_ISO]) |->
            (o_mouse_clk_to_mcu == $past(i_mouse_clk_line)) &&
            (o_mouse_data_to_mcu == $past(i_mouse_data_line)))
        else $error("mouse lines not passed through");

    a_mouse_wake_path: assert property (@(posedge i_clk)
        disable iff (any_rst || !settled)
        o_mouse_wake_data == $past(i_mouse_data_line))
        else $error("mouse wake data gated");

    a_kbd_iso_block: assert property (@(posedge i_clk)
        disable iff (any_rst || !settled)
        $past(kbd_signal_select[SEL_KBD_ISO]) |->
            (o_kbd_clk_to_mcu && o_kbd_data_to_mcu))
        else $error("keyboard lines not held idle while isolated");

    a_kbd_wake_path: assert property (@(posedge i_clk)
        disable iff (any_rst || !settled)
        o_kbd_wake_data == $past(i_kbd_data_line))
        else $error("keyboard wake data gated");

    a_sys_port_en: assert property (@(posedge i_clk)
        disable iff (any_rst || !settled)
        o_sys_ctrl_port_en == $past(kbd_signal_select[SEL_SYS_PORT]))
        else $error("system-control port enable wrong");

    a_rsvd_read_zero: assert property (@(posedge i_clk)
        disable iff (any_rst)
        (bus_state == BUS_IDLE && i_avs_read && is_reserved(req_idx))
            |=> (o_avs_readdata == 32'h0000_0000) && !o_avs_waitrequest)
        else $error("reserved index read non-zero");

    a_iso_keep_reset: assert property (@(posedge i_clk)
        disable iff (!i_standby_por_n)
        (!i_reset_n && !wr_lane0) |=> $stable(select_iso))
        else $error("isolation bits lost on bus reset");

    a_ldn_gate: assert property (@(posedge i_clk)
        disable iff (any_rst)
        (bus_state == BUS_IDLE && i_avs_read && req_idx == IDX_SELECT &&
            ldn != LDN_KBD) |=> o_avs_readdata == 32'h0000_0000)
        else $error("select readable outside its logical device");

    a_bus_answer: assert property (@(posedge i_clk)
        disable iff (any_rst)
        (o_avs_waitrequest && (i_avs_read || i_avs_write))
            |=> !o_avs_waitrequest ##1 o_avs_waitrequest)
        else $error("waitrequest answer not one cycle");

    a_status_set_wins: assert property (@(posedge i_clk)
        disable iff (any_rst)
        (|irq_events) |=> ((irq_status & $past(irq_events)) ==
            $past(irq_events)))
        else $error("interrupt event lost");

    c_select_write: cover property (@(posedge i_clk)
        wr_lane0 && is_select(req_idx, ldn));
    c_mouse_isolated: cover property (@(posedge i_clk)
        kbd_signal_select[SEL_MOUSE_ISO] && !i_mouse_clk_line);
    c_kbd_irq_latched: cover property (@(posedge i_clk)
        kbd_signal_select[SEL_KBD_LATCH] && o_kbd_irq);
    c_status_clear: cover property (@(posedge i_clk)
        rd_done && req_idx == IDX_IRQ_STATUS && |irq_status);

endmodule : kbdss_signal_select

//--- verif/kbdss_mcu_model.sv
// Stand-in for the keyboard microcontroller and keyboard/mouse pins.
`timescale 1ns/1ps
module kbdss_mcu_model (
    input  wire logic [6:0] i_cmd,
    output wire logic [3:0] o_lines,
    output wire logic       o_bit_twelve,
    output wire logic [1:0] o_raw_irq
);
    // The bench paces the commands, so the model adds no delay of its own.
    assign o_lines      = i_cmd[3:0];
    assign o_bit_twelve = i_cmd[4];
    assign o_raw_irq    = i_cmd[6:5];
endmodule : kbdss_mcu_model

//--- verif/kbd_ctrl_signal_select_reg_tb_top.sv
// Self-checking bench for the signal select register block.
`timescale 1ns/1ps
module kbd_ctrl_signal_select_reg_tb_top;
    import kbdss_pkg::*;
    logic i_clk, i_reset_n, i_main_por_n, i_standby_por_n;
    logic [ADDR_W-1:0] i_avs_address;
    logic i_avs_read, i_avs_write, i_kbd_irq_ack, i_mouse_irq_ack;
    logic [31:0] i_avs_writedata, got, r;
    logic [3:0] i_avs_byteenable;
    wire logic [31:0] o_avs_readdata;
    wire logic o_avs_waitrequest, o_kbd_clk_to_mcu, o_kbd_data_to_mcu;
    wire logic o_mouse_clk_to_mcu, o_mouse_data_to_mcu, o_kbd_wake_data;
    wire logic o_mouse_wake_data, o_kbd_driven_cpu_reset, o_kbd_irq;
    wire logic o_mouse_irq, o_sys_ctrl_port_en, o_irq;
    wire logic i_kbd_clk_line, i_kbd_data_line, i_mouse_clk_line;
    wire logic i_mouse_data_line, i_ctrl_port_bit_twelve;
    wire logic i_mcu_kbd_irq, i_mcu_mouse_irq;
    logic [6:0] cmd;
    logic [7:0] sel;
    logic [31:0] seed;
    int mismatches, check_count, n;
    wire logic [7:0] pins = {o_kbd_clk_to_mcu, o_kbd_data_to_mcu,
        o_mouse_clk_to_mcu, o_mouse_data_to_mcu, o_kbd_wake_data,
        o_mouse_wake_data, o_kbd_driven_cpu_reset, o_sys_ctrl_port_en};

    kbdss_signal_select uut (.i_clk, .i_reset_n, .i_main_por_n,
        .i_standby_por_n, .i_avs_address, .i_avs_read, .i_avs_write,
        .i_avs_writedata, .i_avs_byteenable, .o_avs_readdata,
        .o_avs_waitrequest, .i_kbd_clk_line, .i_kbd_data_line,
        .i_mouse_clk_line, .i_mouse_data_line, .o_kbd_clk_to_mcu,
        .o_kbd_data_to_mcu, .o_mouse_clk_to_mcu, .o_mouse_data_to_mcu,
        .o_kbd_wake_data, .o_mouse_wake_data, .i_ctrl_port_bit_twelve,
        .o_kbd_driven_cpu_reset, .i_mcu_kbd_irq, .i_mcu_mouse_irq,
        .i_kbd_irq_ack, .i_mouse_irq_ack, .o_kbd_irq, .o_mouse_irq,
        .o_sys_ctrl_port_en, .o_irq);
    kbdss_mcu_model mcu (.i_cmd(cmd), .o_lines({i_kbd_clk_line,
        i_kbd_data_line, i_mouse_clk_line, i_mouse_data_line}),
        .o_bit_twelve(i_ctrl_port_bit_twelve),
        .o_raw_irq({i_mcu_mouse_irq, i_mcu_kbd_irq}));

    // -------------------------------------------------------------------
    // Helpers
    // -------------------------------------------------------------------
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    // Blocked lines read idle high; wake lines always follow the pins.
    function automatic logic [7:0] exp_pins(input logic [7:0] s,
                                            input logic [4:0] c);
        return {c[3:2] | {2{s[SEL_KBD_ISO]}}, c[1:0] | {2{s[SEL_MOUSE_ISO]}},
                c[2], c[0], c[4] ^ ~s[SEL_P12_POL], s[SEL_SYS_PORT]};
    endfunction : exp_pins

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, mismatches);
        if (mismatches == 0 && check_count > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk

    // The slave's answer time is not assumed; only the bound cuts it short.
    task automatic bus(input logic we, input logic [7:0] idx,
                       input logic [7:0] d, output logic [31:0] q);
        @(posedge i_clk);
        i_avs_read      <= !we;
        i_avs_write     <= we;
        i_avs_address   <= {idx, 2'b00};
        i_avs_writedata <= {24'h000000, d};
        n = 0;
        do begin
            @(posedge i_clk);
            n++;
        end while (o_avs_waitrequest !== 1'b0 && n < 20);
        if (o_avs_waitrequest !== 1'b0) begin
            mismatches++;
            report_and_stop();
        end
        q = o_avs_readdata;
        i_avs_read  <= 1'b0;
        i_avs_write <= 1'b0;
    endtask : bus

    initial begin
        i_clk = 1'b0;
        forever #5 i_clk = ~i_clk;
    end

    // -------------------------------------------------------------------
    // Main sequence
    // -------------------------------------------------------------------
    initial begin
        seed = 32'h076353DC;
        {i_reset_n, i_main_por_n, i_standby_por_n} = 3'h0;
        {i_avs_read, i_avs_write, i_kbd_irq_ack, i_mouse_irq_ack} = 4'h0;
        i_avs_address = '0;
        i_avs_writedata = 32'h0;
        i_avs_byteenable = 4'hF;
        cmd = 7'h0F;
        repeat (5) @(posedge i_clk);
        {i_reset_n, i_main_por_n, i_standby_por_n} <= 3'h7;
        bus(1'b1, IDX_SELECT, 8'hFF, got);
        bus(1'b0, IDX_SELECT, 8'h00, got);
        chk(got, 32'h0);
        bus(1'b1, IDX_LDN, LDN_KBD, got);
        bus(1'b0, IDX_SELECT, 8'h00, got);
        chk(got, 32'h0);
        repeat (24) begin
            r = rnd();
            sel = r[15:8];
            bus(1'b1, IDX_SELECT, sel, got);
            bus(1'b0, IDX_SELECT, 8'h00, got);
            chk(got, {24'h0, sel & SELECT_WMASK});
            cmd <= {2'b00, r[4:0]};
            repeat (2) @(posedge i_clk);
            sel = exp_pins(sel, cmd[4:0]);
            chk({24'h0, pins}, {24'h0, sel});
        end
        for (int i = 8'hF1; i <= 8'hFF; i++) begin
            bus(1'b1, 8'(i), 8'hA5, got);
            bus(1'b0, 8'(i), 8'h00, got);
            chk(got, 32'h0);
        end
        for (int m = 0; m < 2; m++) begin
            bus(1'b1, IDX_IRQ_MASK, {7'h00, m[0]}, got);
            bus(1'b0, IDX_IRQ_MASK, 8'h00, got);
            chk(got, {31'h0, m[0]});
            bus(1'b1, IDX_SELECT, m[0] ? 8'h18 : 8'h00, got);
            bus(1'b0, IDX_IRQ_STATUS, 8'h00, got);
            cmd <= 7'h6F;
            repeat (4) @(posedge i_clk);
            chk({29'h0, o_kbd_irq, o_mouse_irq, o_irq}, 32'h6 | m);
            cmd <= 7'h0F;
            repeat (3) @(posedge i_clk);
            chk({30'h0, o_kbd_irq, o_mouse_irq}, {30'h0, {2{m[0]}}});
            bus(1'b0, IDX_IRQ_STATUS, 8'h00, got);
            chk(got, 32'h3);
            bus(1'b0, IDX_IRQ_STATUS, 8'h00, got);
            chk(got, 32'h0);
            {i_kbd_irq_ack, i_mouse_irq_ack} <= 2'h3;
            @(posedge i_clk);
            {i_kbd_irq_ack, i_mouse_irq_ack} <= 2'h0;
            repeat (3) @(posedge i_clk);
            chk({29'h0, o_kbd_irq, o_mouse_irq, o_irq}, 32'h0);
        end
        // A write without its low byte lane must leave the register alone.
        bus(1'b1, IDX_SELECT, 8'hFC, got);
        i_avs_byteenable <= 4'hE;
        bus(1'b1, IDX_SELECT, 8'h00, got);
        i_avs_byteenable <= 4'hF;
        bus(1'b0, IDX_SELECT, 8'h00, got);
        chk(got, 32'h0000_00FC);
        // Bus reset and main power-on keep the isolation bits.
        for (int k = 0; k < 2; k++) begin
            bus(1'b1, IDX_SELECT, 8'hFC, got);
            {i_reset_n, i_main_por_n} <= k[0] ? 2'h2 : 2'h1;
            @(posedge i_clk);
            {i_reset_n, i_main_por_n} <= 2'h3;
            bus(1'b1, IDX_LDN, LDN_KBD, got);
            bus(1'b0, IDX_SELECT, 8'h00, got);
            chk(got, {24'h0, SELECT_ISO_MASK});
        end
        // Standby power-on clears them.
        i_standby_por_n <= 1'b0;
        @(posedge i_clk);
        i_standby_por_n <= 1'b1;
        bus(1'b1, IDX_LDN, LDN_KBD, got);
        bus(1'b0, IDX_SELECT, 8'h00, got);
        chk(got, 32'h0);
        report_and_stop();
    end
endmodule : kbd_ctrl_signal_select_reg_tb_top
